//--- design/pcstp_pkg.sv
// package for the serial transceiver port of the pcs/pma block
// assumes one clock domain, the transmit reference clock, shared with the transceiver
package pcstp_pkg;

  // receive synchronisation states, a reduced form of the 1000base-x sync machine
  typedef enum logic [1:0] {
    PCSTP_LOSS_OF_SYNC,
    PCSTP_COMMA_DETECT,
    PCSTP_SYNC_ACQUIRED
  } pcstp_sync_state_t;

  // commas with no invalid code group between them needed before sync is declared
  localparam logic [1:0] PCSTP_COMMAS_TO_SYNC = 2'h3;
  // consecutive good code groups counted before the next one undoes one level of degradation
  localparam logic [1:0] PCSTP_GOOD_CGS_TO_HEAL = 2'h3;
  // degradation levels tolerated while in sync; one more drops sync
  localparam logic [1:0] PCSTP_MAX_BAD_LEVEL = 2'h3;
  // elastic buffer status bit that flags overflow or underflow
  localparam int PCSTP_BUF_ERR_BIT = 1;
  // stages of the reset release and pin synchronisers
  localparam int PCSTP_SYNC_STAGES = 2;
  // reset values
  localparam logic [7:0] PCSTP_TX_DATA_RST = 8'h00;
  localparam logic [4:0] PCSTP_PHY_ADDR_RST = 5'h00;

  // per-byte receive information from the transceiver
  typedef struct packed {
    logic [7:0] rx_data;
    logic rx_kchar_flag;
    logic rx_running_disparity;
    logic rx_invalid_code;
    logic rx_disparity_error;
    logic rx_comma_flag;
    logic phy_rx_valid_input;
    logic [1:0] rx_elastic_buf_status;
    logic [2:0] rx_clock_corr_count;
    logic tx_buffer_error;
  } pcstp_xcvr_rx_t;

  // per-byte transmit controls toward the transceiver
  typedef struct packed {
    logic [7:0] phy_tx_data_bus;
    logic tx_kchar_flag;
    logic tx_disp_override_mode;
    logic tx_disp_value;
  } pcstp_xcvr_tx_t;

  // decoded receive word toward the pcs core
  typedef struct packed {
    logic [9:0] word;
    logic is_k;
    logic is_comma;
    logic code_error;
    logic valid_cg;
  } pcstp_rx_word_t;

endpackage

//--- design/pcstp_port.sv
// serial transceiver port of the pcs/pma block: transceiver controls, byte
// transmit controls, receive flag decoding, receive sync machine, status
// assumes the transceiver's parallel side runs on clk_sys, the transmit
// reference clock; only reset, signal detect, lock and the address strap are async
`timescale 1ns/1ps

// Notes on behaviour
// [R1] sync status high only while sync acquired
// [R2] buffer status bit one means overflow/underflow
// [R3] invalid code: k flag is tenth bit
// [R4] invalid code: running disparity is ninth bit
// [R5] surroundings supply five bit pcs address
// [R6] signal detect high means light present
// [R7] unused signal detect is tied high
// [R8] drive comma realign enable to transceiver
// [R9] drive transceiver loopback control
// [R10] separate rx and tx transceiver resets
// [R11] drive transceiver power down
// [R12] per byte k, disparity mode, disparity value
// [R13] use comma, disparity, invalid flags in decoding
// [R14] accept transmit buffer error input
// [R15] accept three bit clock correction status
// [R16] raise interrupt on auto-negotiation event
// [R17] surroundings supply transmit reference clock
// [R18] global reset acts asynchronously
// [R19] held in reset while lock is low
// [R20] lock is clock manager and pll lock anded
// [R21] no clock manager: lock tied high
// [R22] eight bit transmit bus carries byte data
// [R23] rx valid input means realignment happened
// [R24] internal reset is reset or not locked
module pcstp_port (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clock_manager_locked,
  input wire logic optical_signal_detect,
  input wire logic [4:0] pcs_phy_address,
  input wire logic cfg_comma_align_en,
  input wire logic cfg_loopback,
  input wire logic cfg_power_down,
  input wire logic cfg_rx_reset,
  input wire logic cfg_tx_reset,
  input wire logic autoneg_int_ack,
  input wire pcstp_pkg::pcstp_xcvr_tx_t tx_in,
  input wire pcstp_pkg::pcstp_xcvr_rx_t xcvr_rx,
  output pcstp_pkg::pcstp_xcvr_tx_t xcvr_tx,
  output pcstp_pkg::pcstp_rx_word_t rx_out,
  output logic comma_realign_enable,
  output logic xcvr_loopback_ctl,
  output logic xcvr_rx_reset_out,
  output logic xcvr_tx_reset_out,
  output logic xcvr_power_down,
  output logic sync_acquired_status,
  output logic autoneg_interrupt,
  output logic signal_present,
  output logic rx_buffer_fault,
  output logic tx_buffer_fault,
  output logic clock_corr_event,
  output logic realign_event,
  output logic [4:0] pcs_address_q
);

  // reset release: reset asserts at once, lock and reset release act after four edges
  logic [1:0] rst_pipe_q;
  logic [1:0] lock_sync_q;
  logic [1:0] lock_sync_d;
  logic rst_int;

  always_comb begin
    lock_sync_d = {lock_sync_q[0], clock_manager_locked};
  end

  // lock passes two flops before it may hold the block in reset
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lock_sync_q <= 2'h0;
    end else begin
      lock_sync_q <= lock_sync_d;
    end
  end

  // asynchronous assertion keeps the block quiet even with no clock running
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rst_pipe_q <= 2'h3; // see [R18]
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], ~lock_sync_q[1]}; // see [R19] see [R24]
    end
  end

  assign rst_int = rst_pipe_q[1];

  // signal detect and the address strap come from pins: two flops first
  logic [1:0] sigdet_q;
  logic [1:0] sigdet_d;
  logic [4:0] addr_meta_q;
  logic [4:0] addr_meta_d;
  logic [4:0] pcs_address_d;

  always_comb begin
    sigdet_d = {sigdet_q[0], optical_signal_detect};
    addr_meta_d = pcs_phy_address;
    // strap is sampled continuously; surroundings keep it static
    pcs_address_d = addr_meta_q; // see [R5]
  end

  // internal reset acts at once, so pins are quiet even with the clock stopped
  always_ff @(posedge clk_sys or posedge rst_int) begin
    if (rst_int) begin
      sigdet_q <= 2'h0;
      addr_meta_q <= pcstp_pkg::PCSTP_PHY_ADDR_RST;
      pcs_address_q <= pcstp_pkg::PCSTP_PHY_ADDR_RST;
    end else begin
      sigdet_q <= sigdet_d;
      addr_meta_q <= addr_meta_d;
      pcs_address_q <= pcs_address_d;
    end
  end

  // receive flag decoding
  logic light_ok;
  logic buf_err;
  logic cg_invalid;
  logic cg_comma;
  pcstp_pkg::pcstp_rx_word_t rx_word_d;

  always_comb begin
    light_ok = sigdet_q[1]; // see [R6]
    buf_err = xcvr_rx.rx_elastic_buf_status[pcstp_pkg::PCSTP_BUF_ERR_BIT]; // see [R2]
    // a disparity error spoils the code group as much as a bad code does
    cg_invalid = xcvr_rx.rx_invalid_code | xcvr_rx.rx_disparity_error; // see [R13]
    cg_comma = xcvr_rx.rx_comma_flag & xcvr_rx.rx_kchar_flag & ~cg_invalid;
    rx_word_d.word[7:0] = xcvr_rx.rx_data;
    if (xcvr_rx.rx_invalid_code) begin
      // no valid symbol: the flags carry the raw upper code bits
      rx_word_d.word[8] = xcvr_rx.rx_running_disparity; // see [R4]
      rx_word_d.word[9] = xcvr_rx.rx_kchar_flag; // see [R3]
      rx_word_d.is_k = 1'b0; // see [R3]
    end else begin
      rx_word_d.word[8] = 1'b0;
      rx_word_d.word[9] = 1'b0;
      rx_word_d.is_k = xcvr_rx.rx_kchar_flag;
    end
    rx_word_d.is_comma = cg_comma;
    rx_word_d.code_error = cg_invalid | buf_err;
    rx_word_d.valid_cg = ~cg_invalid & ~buf_err;
  end

  // receive sync machine
  pcstp_pkg::pcstp_sync_state_t state_q;
  pcstp_pkg::pcstp_sync_state_t state_d;
  logic [1:0] comma_cnt_q;
  logic [1:0] comma_cnt_d;
  logic [1:0] bad_lvl_q;
  logic [1:0] bad_lvl_d;
  logic [1:0] good_cnt_q;
  logic [1:0] good_cnt_d;

  // losing light or a buffer slip means bytes are unreliable: restart
  always_comb begin
    state_d = state_q;
    comma_cnt_d = comma_cnt_q;
    bad_lvl_d = bad_lvl_q;
    good_cnt_d = good_cnt_q;
    if (!light_ok || buf_err) begin
      state_d = pcstp_pkg::PCSTP_LOSS_OF_SYNC; // see [R6] see [R2]
      comma_cnt_d = 2'h0;
      bad_lvl_d = 2'h0;
      good_cnt_d = 2'h0;
    end else begin
      unique case (state_q)
        pcstp_pkg::PCSTP_LOSS_OF_SYNC: begin
          if (cg_comma) begin
            state_d = pcstp_pkg::PCSTP_COMMA_DETECT;
            comma_cnt_d = 2'h1;
          end
        end
        pcstp_pkg::PCSTP_COMMA_DETECT: begin
          if (cg_invalid) begin
            state_d = pcstp_pkg::PCSTP_LOSS_OF_SYNC;
            comma_cnt_d = 2'h0;
          end else if (cg_comma) begin
            // extra commas hold the count rather than wrapping it back to zero
            if (comma_cnt_q != pcstp_pkg::PCSTP_COMMAS_TO_SYNC) begin
              comma_cnt_d = comma_cnt_q + 2'h1;
            end
          end else if (comma_cnt_q == pcstp_pkg::PCSTP_COMMAS_TO_SYNC) begin
            // data after the last comma completes acquisition
            state_d = pcstp_pkg::PCSTP_SYNC_ACQUIRED;
            bad_lvl_d = 2'h0;
            good_cnt_d = 2'h0;
          end
        end
        pcstp_pkg::PCSTP_SYNC_ACQUIRED: begin
          if (cg_invalid) begin
            good_cnt_d = 2'h0;
            if (bad_lvl_q == pcstp_pkg::PCSTP_MAX_BAD_LEVEL) begin
              state_d = pcstp_pkg::PCSTP_LOSS_OF_SYNC;
              bad_lvl_d = 2'h0;
              comma_cnt_d = 2'h0;
            end else begin
              bad_lvl_d = bad_lvl_q + 2'h1;
            end
          end else if (bad_lvl_q != 2'h0) begin
            if (good_cnt_q == pcstp_pkg::PCSTP_GOOD_CGS_TO_HEAL) begin
              bad_lvl_d = bad_lvl_q - 2'h1;
              good_cnt_d = 2'h0;
            end else begin
              good_cnt_d = good_cnt_q + 2'h1;
            end
          end
        end
      endcase
    end
  end

  // a global reset must drop sync without waiting for a clock edge
  always_ff @(posedge clk_sys or posedge rst_int) begin // see [R18]
    if (rst_int) begin
      state_q <= pcstp_pkg::PCSTP_LOSS_OF_SYNC;
      comma_cnt_q <= 2'h0;
      bad_lvl_q <= 2'h0;
      good_cnt_q <= 2'h0;
    end else begin
      state_q <= state_d;
      comma_cnt_q <= comma_cnt_d;
      bad_lvl_q <= bad_lvl_d;
      good_cnt_q <= good_cnt_d;
    end
  end

  // status, interrupt and transceiver controls
  logic sync_d;
  logic irq_d;
  logic realign_en_d;
  logic rx_rst_d;
  logic tx_rst_d;
  logic cc_d;
  logic loop_d;
  logic pdn_d;
  logic sigp_d;
  logic rxbf_d;
  logic txbf_d;
  logic rlgn_d;
  pcstp_pkg::pcstp_xcvr_tx_t tx_d;

  always_comb begin
    sync_d = (state_d == pcstp_pkg::PCSTP_SYNC_ACQUIRED); // see [R1]
    // any change of sync restarts negotiation; set beats a same-cycle ack
    if (sync_d != sync_acquired_status) begin
      irq_d = 1'b1; // see [R16]
    end else if (autoneg_int_ack) begin
      irq_d = 1'b0;
    end else begin
      irq_d = autoneg_interrupt;
    end
    // realigning on commas while synced would shift a good word boundary
    realign_en_d = cfg_comma_align_en & ~sync_d; // see [R8]
    // a slipped buffer is recovered by resetting that transceiver side
    rx_rst_d = rst_int | cfg_rx_reset | buf_err; // see [R10]
    tx_rst_d = rst_int | cfg_tx_reset | xcvr_rx.tx_buffer_error; // see [R10] see [R14]
    cc_d = (xcvr_rx.rx_clock_corr_count != 3'h0); // see [R15]
    loop_d = cfg_loopback; // see [R9]
    pdn_d = cfg_power_down; // see [R11]
    sigp_d = light_ok;
    rxbf_d = buf_err;
    txbf_d = xcvr_rx.tx_buffer_error; // see [R14]
    rlgn_d = xcvr_rx.phy_rx_valid_input; // see [R23]
    tx_d = tx_in; // see [R12] see [R22]
  end

  // internal reset acts at once: transceiver resets go high, the rest clear
  always_ff @(posedge clk_sys or posedge rst_int) begin // see [R18]
    if (rst_int) begin
      sync_acquired_status <= 1'b0;
      autoneg_interrupt <= 1'b0;
      comma_realign_enable <= 1'b0;
      xcvr_loopback_ctl <= 1'b0;
      xcvr_power_down <= 1'b0;
      xcvr_rx_reset_out <= 1'b1;
      xcvr_tx_reset_out <= 1'b1;
      signal_present <= 1'b0;
      rx_buffer_fault <= 1'b0;
      tx_buffer_fault <= 1'b0;
      clock_corr_event <= 1'b0;
      realign_event <= 1'b0;
      rx_out <= '0;
      xcvr_tx.phy_tx_data_bus <= pcstp_pkg::PCSTP_TX_DATA_RST;
      xcvr_tx.tx_kchar_flag <= 1'b0;
      xcvr_tx.tx_disp_override_mode <= 1'b0;
      xcvr_tx.tx_disp_value <= 1'b0;
    end else begin
      sync_acquired_status <= sync_d;
      autoneg_interrupt <= irq_d;
      comma_realign_enable <= realign_en_d;
      xcvr_loopback_ctl <= loop_d;
      xcvr_power_down <= pdn_d;
      xcvr_rx_reset_out <= rx_rst_d;
      xcvr_tx_reset_out <= tx_rst_d;
      signal_present <= sigp_d;
      rx_buffer_fault <= rxbf_d;
      tx_buffer_fault <= txbf_d;
      clock_corr_event <= cc_d;
      realign_event <= rlgn_d;
      rx_out <= rx_word_d;
      xcvr_tx <= tx_d;
    end
  end

endmodule

//--- testbench/pcstp_xcvr_model.sv
// transceiver stand-in on the far side of the port
// assumes the bench drives line_in just after each clk_sys edge
`timescale 1ns/1ps
module pcstp_xcvr_model (
  input wire logic xcvr_loopback_ctl,
  input wire logic xcvr_power_down,
  input wire pcstp_pkg::pcstp_xcvr_tx_t xcvr_tx,
  input wire pcstp_pkg::pcstp_xcvr_rx_t line_in,
  output pcstp_pkg::pcstp_xcvr_rx_t xcvr_rx
);
  // loopback returns the sent byte; a powered-down receiver never holds valid data
  always_comb begin
    xcvr_rx = line_in;
    if (xcvr_loopback_ctl) begin
      xcvr_rx.rx_data = xcvr_tx.phy_tx_data_bus;
      xcvr_rx.rx_kchar_flag = xcvr_tx.tx_kchar_flag;
      xcvr_rx.rx_comma_flag = xcvr_tx.tx_kchar_flag;
    end
    if (xcvr_power_down) begin
      xcvr_rx.rx_data = ~xcvr_rx.rx_data;
      xcvr_rx.rx_invalid_code = 1'b1;
    end
  end
endmodule

//--- testbench/pcstp_port_sva.sv
// assertions on the serial transceiver port, seen from its ports only
// assumes clk_sys alone and the active-high reset port
`timescale 1ns/1ps
module pcstp_port_sva (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clock_manager_locked,
  input wire pcstp_pkg::pcstp_xcvr_tx_t tx_in,
  input wire pcstp_pkg::pcstp_xcvr_rx_t xcvr_rx,
  input wire pcstp_pkg::pcstp_xcvr_tx_t xcvr_tx,
  input wire pcstp_pkg::pcstp_rx_word_t rx_out,
  input wire logic comma_realign_enable,
  input wire logic xcvr_rx_reset_out,
  input wire logic xcvr_tx_reset_out,
  input wire logic sync_acquired_status,
  input wire logic autoneg_interrupt,
  input wire logic signal_present
);
  logic [2:0] up_q;
  logic [2:0] up_d;
  wire ready = up_q == 3'h7;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // cycles since reset and lock let go; the internal reset trails them
  always_comb begin
    up_d = (reset || !clock_manager_locked) ? 3'h0 : up_q + 3'(up_q != 3'h7);
  end
  always_ff @(posedge clk_sys) begin
    up_q <= up_d;
  end
  property p_sync_lost; !signal_present [*2] |-> !sync_acquired_status; endproperty
  a_sync_lost: assert property (p_sync_lost) else $error("sync without light");
  property p_buf; ready && xcvr_rx.rx_elastic_buf_status[1] |=> !sync_acquired_status;
  endproperty
  a_buf: assert property (p_buf) else $error("buffer fault missed");
  property p_tenth; ready && xcvr_rx.rx_invalid_code |=>
    rx_out.word[9] == $past(xcvr_rx.rx_kchar_flag); endproperty
  a_tenth: assert property (p_tenth) else $error("tenth bit wrong");
  property p_ninth; ready && xcvr_rx.rx_invalid_code |=>
    rx_out.code_error && rx_out.word[8] == $past(xcvr_rx.rx_running_disparity); endproperty
  a_ninth: assert property (p_ninth) else $error("ninth bit wrong");
  property p_realign; comma_realign_enable |-> !sync_acquired_status; endproperty
  a_realign: assert property (p_realign) else $error("realign while synced");
  property p_tx_copy; ready |=> xcvr_tx == $past(tx_in); endproperty
  a_tx_copy: assert property (p_tx_copy) else $error("tx byte not copied");
  property p_lock; !clock_manager_locked [*6] |->
    xcvr_rx_reset_out && xcvr_tx_reset_out && !sync_acquired_status; endproperty
  a_lock: assert property (p_lock) else $error("reset not held");
  property p_an; ready && $changed(sync_acquired_status) |-> ##[0:1] autoneg_interrupt;
  endproperty
  a_an: assert property (p_an) else $error("no interrupt");
  c_sync_up: cover property ($rose(sync_acquired_status));
  c_bad_code: cover property (ready && xcvr_rx.rx_invalid_code);
  c_lock_low: cover property (!clock_manager_locked [*6]);
endmodule
bind pcstp_port pcstp_port_sva i_pcstp_port_sva (
  .clk_sys, .reset, .clock_manager_locked, .tx_in, .xcvr_rx, .xcvr_tx, .rx_out,
  .comma_realign_enable, .xcvr_rx_reset_out, .xcvr_tx_reset_out, .sync_acquired_status,
  .autoneg_interrupt, .signal_present
);

//--- testbench/pcstp_port_tb_top.sv
// self-checking bench for the serial transceiver port
// assumes the port checker is bound in and the transceiver model answers it
`timescale 1ns/1ps
module pcstp_port_tb_top;
  typedef struct packed {
    logic [7:0] data;
    logic [2:0] flags;
    logic [5:0] ctl;
    logic [2:0] ccnt;
  } pcstp_row_t;
  // byte, {k, disp mode, disp value}, {loop, power, tx err, realign, tx rst, rx rst}, corr
  pcstp_row_t rows[6] = '{'{8'hBC, 3'h4, 6'h00, 3'h0}, '{8'h5A, 3'h2, 6'h20, 3'h1},
    '{8'hA5, 3'h3, 6'h10, 3'h2}, '{8'hFF, 3'h1, 6'h08, 3'h4}, '{8'h00, 3'h0, 6'h04, 3'h7},
    '{8'h3C, 3'h5, 6'h03, 3'h0}};
  pcstp_row_t r;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic clock_manager_locked = 1'b1;
  logic optical_signal_detect = 1'b1;
  logic [4:0] pcs_phy_address = 5'h15;
  logic cfg_comma_align_en = 1'b1;
  logic cfg_loopback = 1'b0, cfg_power_down = 1'b0, cfg_rx_reset = 1'b0, cfg_tx_reset = 1'b0;
  logic autoneg_int_ack = 1'b0;
  pcstp_pkg::pcstp_xcvr_tx_t tx_in = '0, xcvr_tx;
  pcstp_pkg::pcstp_xcvr_rx_t line_in = '0, xcvr_rx;
  pcstp_pkg::pcstp_rx_word_t rx_out;
  logic comma_realign_enable, xcvr_loopback_ctl, xcvr_rx_reset_out, xcvr_tx_reset_out;
  logic xcvr_power_down, sync_acquired_status, autoneg_interrupt, signal_present;
  logic rx_buffer_fault, tx_buffer_fault, clock_corr_event, realign_event;
  logic [4:0] pcs_address_q;
  int num_errors = 0, comparisons = 0;
  // 40 MHz transmit reference clock
  always #12.5 clk_sys = !clk_sys;
  pcstp_port i_pcstp_port (
    .clk_sys, .reset, .clock_manager_locked, .optical_signal_detect, .pcs_phy_address,
    .cfg_comma_align_en, .cfg_loopback, .cfg_power_down, .cfg_rx_reset, .cfg_tx_reset,
    .autoneg_int_ack, .tx_in, .xcvr_rx, .xcvr_tx, .rx_out, .comma_realign_enable,
    .xcvr_loopback_ctl, .xcvr_rx_reset_out, .xcvr_tx_reset_out, .xcvr_power_down,
    .sync_acquired_status, .autoneg_interrupt, .signal_present, .rx_buffer_fault,
    .tx_buffer_fault, .clock_corr_event, .realign_event, .pcs_address_q
  );
  pcstp_xcvr_model i_pcstp_xcvr_model (
    .xcvr_loopback_ctl, .xcvr_power_down, .xcvr_tx, .line_in, .xcvr_rx
  );
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // inputs change 2 ns after the edge, so outputs read there have settled
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  // three commas, each followed by a valid byte, win sync
  task automatic acquire();
    repeat (3) begin
      {line_in.rx_kchar_flag, line_in.rx_comma_flag, line_in.rx_data} = 10'h3BC;
      step(1);
      check("comma", 16'({rx_out.is_k, rx_out.is_comma, rx_out.valid_cg}), 16'h7);
      {line_in.rx_kchar_flag, line_in.rx_comma_flag, line_in.rx_data} = 10'h04A;
      step(1);
    end
    check("sync", 16'(sync_acquired_status), 16'h1);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    step(5);
    check("rst", 16'({xcvr_rx_reset_out, xcvr_tx_reset_out, sync_acquired_status}),
      16'h6);
    reset = 1'b0;
    step(8);
    check("addr", 16'(pcs_address_q), 16'h15);
    foreach (rows[i]) begin
      r = rows[i];
      tx_in = {r.data, r.flags};
      {cfg_loopback, cfg_power_down, line_in.tx_buffer_error, line_in.phy_rx_valid_input,
        cfg_tx_reset, cfg_rx_reset} = r.ctl;
      line_in.rx_clock_corr_count = r.ccnt;
      step(1);
      check("tx", 16'(xcvr_tx), 16'({r.data, r.flags}));
      check("ctl", 16'({xcvr_loopback_ctl, xcvr_power_down, tx_buffer_fault, clock_corr_event,
        realign_event, xcvr_tx_reset_out, xcvr_rx_reset_out}), 16'({r.ctl[5:3], |r.ccnt,
        r.ctl[2], r.ctl[3] | r.ctl[1], r.ctl[0]}));
    end
    {cfg_loopback, cfg_power_down, cfg_tx_reset, cfg_rx_reset} = 4'h0;
    tx_in = '0;
    line_in = '0;
    $display("rows done");
    // lock low must keep the port in reset, even against a loopback request
    clock_manager_locked = 1'b0;
    cfg_loopback = 1'b1;
    step(8);
    check("lock", 16'({xcvr_rx_reset_out, xcvr_tx_reset_out, xcvr_loopback_ctl}),
      16'h6);
    clock_manager_locked = 1'b1;
    cfg_loopback = 1'b0;
    step(8);
    acquire();
    check("an", 16'({autoneg_interrupt, comma_realign_enable}), 16'h2);
    autoneg_int_ack = 1'b1;
    step(1);
    autoneg_int_ack = 1'b0;
    check("ack", 16'(autoneg_interrupt), 16'h0);
    $display("sync done");
    // four bad code groups in a row: the fourth drops sync
    {line_in.rx_invalid_code, line_in.rx_kchar_flag, line_in.rx_data} = 10'h396;
    step(1);
    check("word k", 16'({rx_out.word, rx_out.is_k, rx_out.valid_cg}), 16'hA58);
    {line_in.rx_kchar_flag, line_in.rx_running_disparity} = 2'h1;
    step(1);
    check("word rd", 16'({rx_out.word, rx_out.code_error}), 16'h32D);
    step(1);
    check("bad 3", 16'(sync_acquired_status), 16'h1);
    step(1);
    check("bad 4", 16'({sync_acquired_status, autoneg_interrupt}), 16'h1);
    line_in = '0;
    acquire();
    line_in.rx_elastic_buf_status = 2'h1;
    step(1);
    check("buf lo", 16'({sync_acquired_status, rx_buffer_fault}), 16'h2);
    line_in.rx_elastic_buf_status = 2'h2;
    step(1);
    check("buf hi", 16'({sync_acquired_status, rx_buffer_fault, xcvr_rx_reset_out}),
      16'h3);
    line_in = '0;
    acquire();
    optical_signal_detect = 1'b0;
    step(4);
    check("light", 16'({sync_acquired_status, signal_present}), 16'h0);
    optical_signal_detect = 1'b1;
    step(4);
    $display("fault tests done");
    acquire();
    reset = 1'b1;
    #1;
    check("async", 16'({xcvr_tx_reset_out, sync_acquired_status}), 16'h2);
    step(5);
    reset = 1'b0;
    step(8);
    check("release", 16'({xcvr_tx_reset_out, xcvr_rx_reset_out}), 16'h0);
    $display("reset tests done");
    close_out();
  end
  // the run needs about 90 cycles; 800 means a hang
  initial begin
    #20000;
    num_errors++;
    close_out();
  end
endmodule
